//--- evpa_arbiter.sv
// Purpose: exception vector and priority arbiter
// Assumes: clk_en high during bus transfers
// Notes: irq lines are asynchronous, filtered here
`timescale 1ns/1ns
`default_nettype none

module evpa_arbiter
   import evpa_pkg::*;
(
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [3:0] hprot,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // peripheral interrupt lines
   input wire logic [NUM_IRQ-1:0] irq_line,
   // core side
   input wire evpa_sys_req_t sys_req,
   input wire evpa_core_in_t core_in,
   output evpa_core_out_t core_out,
   // summary interrupt
   output logic evt_irq
);

   // ==========
   // state
   logic [31:0] vtor_q; // vector table base
   logic [2:0] prio_q [NUM_EXC]; // configurable priorities
   logic [NUM_IRQ-1:0] irq_en_q; // peripheral enables
   logic [NUM_EXC-1:0] pend_q; // pending per exception
   logic [NUM_EXC-1:0] act_q; // active per exception
   logic [NUM_IRQ-1:0] s1_q, s2_q, s3_q; // irq synchroniser
   logic [NUM_IRQ-1:0] filt_q; // agreed irq level
   logic [NUM_ST-1:0] stat_q; // sticky events
   logic [NUM_ST-1:0] ien_q; // event enables
   logic wr_q; // write data phase pending
   logic [5:0] wr_idx_q; // its word index
   logic wr_priv_q; // its privilege
   logic preempt_d1_q; // last preempt level, for edges
   evpa_core_out_t out_q; // registered answer to the core
   logic [31:0] rdata_q; // registered read data
   logic int_q; // registered interrupt

   // ==========
   // bus decode
   logic addr_ok; // address phase accepted
   logic [5:0] a_idx; // read word index
   logic wr_go; // write happens now
   logic [NUM_EXC-1:0] wmask; // words written this cycle, per exception

   assign addr_ok = hsel && htrans[1] && hready;
   assign a_idx = haddr[7:2];
   assign wr_go = wr_q;

   // ==========
   // effective priorities, widened so the fixed ones sit below zero
   logic [NUM_EXC*4-1:0] eff; // flat 4-bit per exception

   for (genvar e = 0; e < NUM_EXC; e++)
   begin : g_eff
      if (e == EXC_NMI)
      begin : g_nmi
         assign eff[e*4 +: 4] = EFF_NMI;
      end
      else if (e == EXC_HARD)
      begin : g_hard
         assign eff[e*4 +: 4] = EFF_HARD;
      end
      else if (CFG_MASK[e])
      begin : g_cfg
         // 0..7 maps to 3..10, always behind the fixed ones
         assign eff[e*4 +: 4] = EFF_OFFSET + {1'b0, prio_q[e]};
      end
      else
      begin : g_none
         assign eff[e*4 +: 4] = EFF_IDLE;
      end
      assign wmask[e] = wr_go && (wr_idx_q == W_PRIO + 6'(e / 8)) && CFG_MASK[e];
   end

   // ==========
   // arbitration
   logic best_found, run_found;
   logic [5:0] best_num, run_num;
   logic [3:0] best_prio, run_prio;
   logic take; // best pending may be entered
   logic [NUM_EXC-1:0] pend_set; // new pending events this cycle

   evpa_pick u_pend_pick (
      .cand(pend_q),
      .eff(eff),
      .found(best_found),
      .num(best_num),
      .prio(best_prio)
   );

   // the running level is the most urgent active handler
   evpa_pick u_run_pick (
      .cand(act_q),
      .eff(eff),
      .found(run_found),
      .num(run_num),
      .prio(run_prio)
   );

   // strictly more urgent only; equal stays pending
   assign take = best_found && (best_prio < run_prio);

   // ==========
   // event sources
   always_comb
   begin
      pend_set = '0;
      // irq n lands on exception n + 16; reserved lines are dropped
      for (int n = 0; n < NUM_IRQ; n++)
      begin
         pend_set[IRQ_BASE + n] = filt_q[n] && irq_en_q[n] && IRQ_USED[n];
      end
      pend_set[EXC_NMI] = sys_req.nmi; // never masked
      pend_set[EXC_HARD] = sys_req.hard_fault;
      pend_set[EXC_MEM] = sys_req.mem_fault;
      pend_set[EXC_BUS] = sys_req.bus_fault;
      pend_set[EXC_USAGE] = sys_req.usage_fault;
      pend_set[EXC_SVC] = sys_req.supervisor_call_exception;
      pend_set[EXC_DEBUG] = sys_req.debug_mon;
      pend_set[EXC_PENDSVC] = sys_req.pendable_service_request;
      pend_set[EXC_TICK] = sys_req.sys_tick;
   end

   // a new event at the running level while a handler runs
   logic eq_pend;
   always_comb
   begin
      eq_pend = 1'b0;
      for (int e = 0; e < NUM_EXC; e++)
      begin
         if (pend_set[e] && !pend_q[e] && run_found && (eff[e*4 +: 4] == run_prio))
         begin
            eq_pend = 1'b1;
         end
      end
   end

   // ==========
   // irq synchroniser: three stages, level changes once two agree
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         filt_q <= '0;
      end
      else if (clk_en)
      begin
         s1_q <= irq_line & IRQ_USED; // reserved lines tied low
         s2_q <= s1_q;
         s3_q <= s2_q;
         // a single stray sample in s2 never reaches the filter
         filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
      end
   end

   // ==========
   // pending and active; a new system event beats a clear in the same cycle, an irq event does not
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pend_q <= '0;
         act_q <= '0;
      end
      else if (clk_en)
      begin
         for (int e = 0; e < NUM_EXC; e++)
         begin
            if (pend_set[e] && !(e >= IRQ_BASE && (act_q[e] || // no re-pend while entered
               (core_in.entry && out_q.req && (out_q.num == 6'(e))))))
            begin
               pend_q[e] <= 1'b1;
            end
            else if (core_in.entry && out_q.req && (out_q.num == 6'(e)))
            begin
               pend_q[e] <= 1'b0;
            end
            // entry sets first, an exit of the same number in that cycle loses
            if (core_in.entry && out_q.req && (out_q.num == 6'(e)))
            begin
               act_q[e] <= 1'b1;
            end
            else if (core_in.exit && (core_in.exit_num == 6'(e)))
            begin
               act_q[e] <= 1'b0;
            end
         end
      end
   end

   // ==========
   // answer to the core
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         out_q <= '0;
         preempt_d1_q <= 1'b0;
      end
      else if (clk_en)
      begin
         out_q.req <= take;
         out_q.preempt <= take && run_found;
         out_q.num <= best_num;
         // handler word at base plus four times the number
         out_q.vec_addr <= vtor_q + {24'h000000, best_num, 2'b00};
         out_q.sp_addr <= vtor_q; // first entry is the stack pointer
         preempt_d1_q <= take && run_found;
      end
   end

   // ==========
   // vector table base; only privileged, in-range writes land
   logic vtor_wr, vtor_ok;
   assign vtor_wr = wr_go && (wr_idx_q == W_VTOR);
   assign vtor_ok = wr_priv_q && (hwdata >= VTOR_MIN) && (hwdata <= VTOR_MAX);

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         vtor_q <= VTOR_RESET;
      end
      else if (clk_en && vtor_wr && vtor_ok)
      begin
         // low byte forced to zero in case software slips on alignment
         vtor_q <= hwdata & VTOR_ALIGN;
      end
   end

   // ==========
   // priority fields and enables
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int e = 0; e < NUM_EXC; e++)
         begin
            prio_q[e] <= PRIO_RESET;
         end
         irq_en_q <= '0;
         ien_q <= '0;
      end
      else if (clk_en)
      begin
         for (int e = 0; e < NUM_EXC; e++)
         begin
            // fixed-priority entries are never written
            if (wmask[e])
            begin
               prio_q[e] <= hwdata[(e % 8) * 4 +: 3];
            end
         end
         if (wr_go && (wr_idx_q == W_EN0))
         begin
            irq_en_q[31:0] <= hwdata & IRQ_USED[31:0];
         end
         if (wr_go && (wr_idx_q == W_EN1))
         begin
            irq_en_q[43:32] <= hwdata[11:0] & IRQ_USED[43:32];
         end
         if (wr_go && (wr_idx_q == W_IEN))
         begin
            ien_q <= hwdata[NUM_ST-1:0];
         end
      end
   end

   // ==========
   // sticky status, write-one-to-clear; a set in the same cycle wins
   logic [NUM_ST-1:0] st_set, st_clr;
   assign st_set[ST_PREEMPT] = take && run_found && !preempt_d1_q;
   assign st_set[ST_EQPEND] = eq_pend;
   assign st_set[ST_VTOR_REJ] = vtor_wr && !vtor_ok;
   assign st_clr = (wr_go && (wr_idx_q == W_CLR)) ? hwdata[NUM_ST-1:0] : '0;

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stat_q <= '0;
         int_q <= 1'b0;
      end
      else if (clk_en)
      begin
         stat_q <= (stat_q & ~st_clr) | st_set;
         // one cycle behind the status bit, kept registered for timing
         int_q <= |(stat_q & ien_q);
      end
   end

   // ==========
   // bus slave: zero wait, read data registered in the address phase
   logic [31:0] rd;
   always_comb
   begin
      rd = 32'h0000_0000;
      case (a_idx)
         W_VTOR: rd = vtor_q;
         W_STAT: rd = {29'h0000_0000, stat_q};
         W_IEN: rd = {29'h0000_0000, ien_q};
         W_STATE: rd = {16'h0000, run_prio, best_prio, 1'b0, take, best_num};
         W_EN0: rd = irq_en_q[31:0];
         W_EN1: rd = {20'h00000, irq_en_q[43:32]};
         W_PEND0: rd = pend_q[47:16];
         W_PEND1: rd = {20'h00000, pend_q[59:48]};
         W_ACT0: rd = act_q[47:16];
         W_ACT1: rd = {20'h00000, act_q[59:48]};
         W_SYS: rd = {act_q[15:0], pend_q[15:0]};
         default:
         begin
            // priority words pack eight 4-bit slots, top bit reads zero
            if (a_idx >= W_PRIO && a_idx <= W_PRIO_LAST)
            begin
               for (int j = 0; j < 8; j++)
               begin
                  if ((int'(a_idx - W_PRIO) * 8 + j) < NUM_EXC)
                  begin
                     rd[j*4 +: 3] = prio_q[int'(a_idx - W_PRIO) * 8 + j];
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_q <= 1'b0;
         wr_idx_q <= 6'h00;
         wr_priv_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         wr_q <= addr_ok && hwrite;
         wr_idx_q <= a_idx;
         wr_priv_q <= hprot[1]; // privileged access flag
         // unmapped words read zero, writes there are dropped
         rdata_q <= (addr_ok && !hwrite) ? rd : 32'h0000_0000;
      end
   end

   // ==========
   // outputs, straight from flops; hreadyout and hresp tied constant
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;
   assign core_out = out_q;
   assign evt_irq = int_q;

endmodule
`default_nettype wire

//--- evpa_core_model.sv
// Purpose: stand-in for the core's exception entry and exit
// Assumes: same clock as the arbiter
// Notes: enters after lag cycles, exits when told
`timescale 1ns/1ns
`default_nettype none

module evpa_core_model
   import evpa_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // arbiter side
   input wire evpa_core_out_t core_out,
   output evpa_core_in_t core_in,
   // bench control
   input wire logic [1:0] lag,
   input wire logic do_exit,
   input wire logic [5:0] exit_num,
   output logic taken,
   output logic [5:0] taken_num
);
   logic [1:0] wait_q; // cycles the request has stood
   logic [1:0] hold_q; // blanking while req falls after an entry

   // ==========
   // entry only while req stands; blanking stops a stale retake
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         core_in <= '0;
         wait_q <= 2'h0;
         hold_q <= 2'h0;
         taken <= 1'b0;
         taken_num <= 6'h0;
      end
      else
      begin
         core_in.entry <= 1'b0;
         taken <= core_in.entry & core_out.req;
         taken_num <= core_out.num;
         core_in.exit <= do_exit;
         core_in.exit_num <= exit_num;
         if (hold_q != 2'h0)
            hold_q <= hold_q - 2'h1;
         else if (core_out.req)
         begin
            if (wait_q >= lag)
            begin
               core_in.entry <= 1'b1;
               hold_q <= 2'h3;
               wait_q <= 2'h0;
            end
            else
               wait_q <= wait_q + 2'h1;
         end
         else
            wait_q <= 2'h0;
      end
   end
endmodule

`default_nettype wire

//--- evpa_monitor.sv
// Purpose: port checks of the arbiter
// Assumes: one clock, bound from the bench
// Notes: judges design outputs only
`timescale 1ns/1ns
`default_nettype none

module evpa_monitor
   import evpa_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // core side
   input wire evpa_sys_req_t sys_req,
   input wire evpa_core_out_t core_out
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   // ==========
   // helpers
   logic rd_q; // this cycle is a read data phase
   logic fresh_q; // first edge after reset release

   // track read data phases so idle hrdata can be judged
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rd_q <= 1'b0;
         fresh_q <= 1'b1;
      end
      else
      begin
         rd_q <= hsel & htrans[1] & hready & ~hwrite;
         fresh_q <= 1'b0;
      end
   end

   // ==========
   // assertions
   a_reset_base: assert property (fresh_q |-> core_out.sp_addr == 32'h0 && !core_out.req)
      else $error("reset state not clear");
   a_vec_offset: assert property (core_out.req |->
      core_out.vec_addr == core_out.sp_addr + {24'h0, core_out.num, 2'b00})
      else $error("vector address wrong");
   a_base_align: assert property (core_out.sp_addr[7:0] == 8'h00)
      else $error("base misaligned");
   a_base_range: assert property (core_out.sp_addr == 32'h0 ||
      (core_out.sp_addr >= 32'h100 && core_out.sp_addr <= 32'h3fff_ff00))
      else $error("base out of range");
   a_preempt_req: assert property (core_out.preempt |-> core_out.req)
      else $error("preempt without request");
   a_nmi_wins: assert property (sys_req.nmi |-> ##2 core_out.req && core_out.num == 6'd2)
      else $error("nmi not presented");
   a_num_legal: assert property (core_out.req |-> core_out.num < 6'd60 &&
      !(core_out.num inside {[0:1], [7:10], 13, [30:33], [53:58]}))
      else $error("reserved number requested");
   a_read_idle: assert property (!rd_q |-> hrdata == 32'h0)
      else $error("read data outside data phase");

   // ==========
   // coverage of the main scenarios
   c_preempt: cover property (core_out.preempt);
   c_nmi: cover property (sys_req.nmi);
   c_read: cover property (rd_q && hrdata != 32'h0);
endmodule

`default_nettype wire

//--- evpa_pick.sv
// Purpose: picks the most urgent exception of a set
// Assumes: 4-bit priorities, smaller is more urgent
// Notes: combinational, caller registers the result
`timescale 1ns/1ns
`default_nettype none

module evpa_pick
   import evpa_pkg::*;
(
   // candidate set
   input wire logic [NUM_EXC-1:0] cand,
   input wire logic [NUM_EXC*4-1:0] eff,
   // winner
   output logic found,
   output logic [5:0] num,
   output logic [3:0] prio
);

   // ==========
   // scan from the top so the lowest number wins a tie
   always_comb
   begin
      found = 1'b0;
      num = 6'h00;
      prio = EFF_IDLE;
      for (int e = NUM_EXC - 1; e >= 0; e--)
      begin
         // smaller value is more urgent, equal lets the lower number in
         if (cand[e] && (eff[e*4 +: 4] <= prio))
         begin
            found = 1'b1;
            num = 6'(e);
            prio = eff[e*4 +: 4];
         end
      end
   end

endmodule
`default_nettype wire

//--- evpa_pkg.sv
// Purpose: constants and types of the arbiter
// Assumes: one clock, AHB-Lite words
// Notes: 3-bit priorities, widened to 4 bits
//
// Functional notes
// - irq n is exception n+16, offset four times
// - configurable priorities reset to zero
// - entry zero holds stack pointer, rest handlers
// - table base is zero after reset
// - privileged write relocates base within range
// - smaller priority value wins
// - reset, hard fault, nmi priorities fixed
// - configurable fields hold only zero to seven
// - equal priority: smallest exception number first
// - strictly higher priority preempts running handler
// - equal priority never preempts, goes pending
// - pendable request 14, system tick 15
// - nmi always enabled, fixed minus two
// - hard fault minus one, reset minus three

package evpa_pkg;

   // ==========
   // sizes
   localparam int NUM_IRQ = 44;
   localparam int NUM_EXC = 60;
   localparam int IRQ_BASE = 16;

   // ==========
   // fixed exception numbers
   localparam int EXC_NMI = 2;
   localparam int EXC_HARD = 3;
   localparam int EXC_MEM = 4;
   localparam int EXC_BUS = 5;
   localparam int EXC_USAGE = 6;
   localparam int EXC_SVC = 11;
   localparam int EXC_DEBUG = 12;
   localparam int EXC_PENDSVC = 14;
   localparam int EXC_TICK = 15;

   // ==========
   // widened priority codes: value plus three, so reset is zero
   localparam logic [3:0] EFF_RESET = 4'h0;
   localparam logic [3:0] EFF_NMI = 4'h1;
   localparam logic [3:0] EFF_HARD = 4'h2;
   localparam logic [3:0] EFF_OFFSET = 4'h3;
   localparam logic [3:0] EFF_IDLE = 4'hf;
   localparam logic [2:0] PRIO_RESET = 3'h0;

   // exceptions whose priority software may change
   localparam logic [59:0] CFG_MASK = 60'h81f_fffc_3fff_d870;
   // irq lines that have a source
   localparam logic [43:0] IRQ_USED = 44'h81f_fffc_3fff;

   // ==========
   // vector table
   localparam logic [31:0] VTOR_RESET = 32'h0000_0000;
   localparam logic [31:0] VTOR_MIN = 32'h0000_0100;
   localparam logic [31:0] VTOR_MAX = 32'h3fff_ff00;
   localparam logic [31:0] VTOR_ALIGN = 32'hffff_ff00;

   // ==========================================================
   // register word indices (byte address is four times)
   localparam logic [5:0] W_VTOR = 6'h00;
   localparam logic [5:0] W_STAT = 6'h01;
   localparam logic [5:0] W_CLR = 6'h02;
   localparam logic [5:0] W_IEN = 6'h03;
   localparam logic [5:0] W_STATE = 6'h04;
   localparam logic [5:0] W_EN0 = 6'h05;
   localparam logic [5:0] W_EN1 = 6'h06;
   localparam logic [5:0] W_PEND0 = 6'h07;
   localparam logic [5:0] W_PEND1 = 6'h08;
   localparam logic [5:0] W_ACT0 = 6'h09;
   localparam logic [5:0] W_ACT1 = 6'h0a;
   localparam logic [5:0] W_SYS = 6'h0b;
   localparam logic [5:0] W_PRIO = 6'h10;
   localparam logic [5:0] W_PRIO_LAST = 6'h17;

   // status bit positions
   localparam int ST_PREEMPT = 0;
   localparam int ST_EQPEND = 1;
   localparam int ST_VTOR_REJ = 2;
   localparam int NUM_ST = 3;

   // ==========
   // system exception event pulses from the core
   typedef struct packed {
      logic nmi;
      logic hard_fault;
      logic mem_fault;
      logic bus_fault;
      logic usage_fault;
      logic supervisor_call_exception;
      logic debug_mon;
      logic pendable_service_request;
      logic sys_tick;
   } evpa_sys_req_t;

   // exception entry/exit handshake from the core
   typedef struct packed {
      logic entry;
      logic exit;
      logic [5:0] exit_num;
   } evpa_core_in_t;

   // arbitration result towards the core
   typedef struct packed {
      logic req;
      logic preempt;
      logic [5:0] num;
      logic [31:0] vec_addr;
      logic [31:0] sp_addr;
   } evpa_core_out_t;

endpackage

//--- test_exception_vector_priority_arbiter.sv
// Purpose: self-checking bench of the arbiter
// Assumes: hreadyout feeds hready
// Notes: reference priorities in an int array
`timescale 1ns/1ns
`default_nettype none

module test_exception_vector_priority_arbiter
   import evpa_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_b, clk_en, hsel, hwrite, hreadyout, hresp, evt_irq, do_exit, taken;
   logic [31:0] haddr, hwdata, hrdata, seed, base, rd;
   logic [1:0] htrans, lag;
   logic [2:0] hsize;
   logic [3:0] hprot;
   logic [43:0] irq_line;
   logic [5:0] exit_num, taken_num;
   evpa_sys_req_t sys_req;
   evpa_core_in_t core_in;
   evpa_core_out_t core_out;
   int err_count = 0, cmp_count = 0, cyc = 0, n, k;
   int prio[60]; // reference priorities, smaller wins
   int q[$];

   evpa_arbiter dut (.core_clk, .rst_b, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hprot, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq_line, .sys_req,
      .core_in, .core_out, .evt_irq);
   evpa_core_model core (.core_clk, .rst_b, .core_out, .core_in, .lag, .do_exit, .exit_num,
      .taken, .taken_num);

   // ==========
   // clock and hang guard
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         wrap_up();
      end
   end

   // ==========
   // compare, bus and reference helpers
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic chk_num(input int e);
      chk_word({26'h0, core_out.num}, 32'(e));
   endtask
   // single transfer, held until hready is sampled high
   task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d,
      input logic [3:0] p = 4'h2);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, idx, 2'b00};
      hwrite <= w;
      hprot <= p;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      rd = hrdata;
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // most urgent of a set: lowest priority value, then lowest number
   function automatic int winner(input int c[$]);
      int b;
      b = c[0];
      foreach (c[i])
         if (prio[c[i]] < prio[b] || (prio[c[i]] == prio[b] && c[i] < b))
            b = c[i];
      return b;
   endfunction
   // rewrite a priority word from the reference array
   task automatic setp(input int e, input int v);
      logic [31:0] w;
      w = 32'h0;
      prio[e] = v;
      for (int j = 0; j < 8; j++)
         w[4*j +: 3] = 3'(prio[8*(e/8)+j]);
      bus(1'b1, W_PRIO + 6'(e/8), w, 4'h2);
   endtask
   task automatic wait_req();
      for (int i = 0; i < 50 && core_out.req !== 1'b1; i++) @(posedge core_clk);
   endtask
   task automatic wait_take();
      for (int i = 0; i < 50 && taken !== 1'b1; i++) @(posedge core_clk);
   endtask
   task automatic leave(input int e);
      @(posedge core_clk);
      do_exit <= 1'b1;
      exit_num <= 6'(e);
      @(posedge core_clk);
      do_exit <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask
   task automatic sys(input evpa_sys_req_t s);
      @(posedge core_clk);
      sys_req <= s;
      @(posedge core_clk);
      sys_req <= '0;
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ==========
   // main sequence
   initial
   begin
      evpa_sys_req_t s;
      logic [31:0] vd[5];
      vd = '{32'h100, 32'h3fff_ff00, 32'h4000_0000, 32'h2000_0000, 32'h0};
      rst_b = 1'b0;
      clk_en = 1'b1;
      {hsel, hwrite, htrans, haddr, hwdata, irq_line, lag, do_exit, exit_num, sys_req} = '0;
      hsize = 3'h2;
      hprot = 4'h2;
      seed = 32'h69c255c9;
      base = 32'h0;
      foreach (prio[i]) prio[i] = 0;
      prio[1] = -3;
      prio[2] = -2;
      prio[3] = -1;
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         bus(1'b0, W_PRIO + 6'(i), 32'h0);
         chk_word(rd, 32'h0);
      end
      bus(1'b1, W_PRIO, 32'hffff_ffff);
      bus(1'b0, W_PRIO, 32'h0);
      chk_word(rd, 32'h0777_0000);
      bus(1'b1, W_PRIO, 32'h0);
      // relocation: accepted twice, above range, unprivileged, below range
      bus(1'b1, W_IEN, 32'h4);
      for (int t = 0; t < 5; t++)
      begin
         bus(1'b1, W_VTOR, vd[t], (t == 3) ? 4'h0 : 4'h2);
         if (t < 2)
            base = vd[t];
         bus(1'b0, W_VTOR, 32'h0);
         chk_word(rd, base);
         repeat (2) @(posedge core_clk);
         chk_bit(evt_irq, t > 1);
         if (t < 4)
            bus(1'b1, W_CLR, 32'h4);
      end
      bus(1'b1, W_IEN, 32'h0);
      repeat (2) @(posedge core_clk);
      chk_bit(evt_irq, 1'b0);
      bus(1'b0, W_STAT, 32'h0);
      chk_word(rd, 32'h4);
      bus(1'b1, W_CLR, 32'h4);
      bus(1'b0, W_STAT, 32'h0);
      chk_word(rd, 32'h0);
      // system tick and pendable request, slow core
      lag <= 2'h3;
      for (int t = 0; t < 2; t++)
      begin
         s = '0;
         s.sys_tick = (t == 0);
         s.pendable_service_request = (t == 1);
         sys(s);
         wait_req();
         chk_num(15 - t);
         chk_word(core_out.vec_addr, base + 32'(4 * (15 - t)));
         wait_take();
         leave(15 - t);
      end
      // random peripheral lines, prompt core
      lag <= 2'h0;
      bus(1'b1, W_EN0, 32'hffff_ffff);
      bus(1'b1, W_EN1, 32'h0000_0fff);
      for (k = 0; k < 6; k++)
      begin
         seed = lfsr(seed);
         n = int'(seed % 44);
         if (!IRQ_USED[n])
            n = 0;
         setp(n + 16, int'(seed[10:8]));
         irq_line[n] <= 1'b1;
         wait_req();
         chk_num(n + 16);
         chk_word(core_out.vec_addr, base + 32'(4 * (n + 16)));
         wait_take();
         irq_line[n] <= 1'b0;
         repeat (6) @(posedge core_clk);
         leave(n + 16);
      end
      irq_line[14] <= 1'b1;
      repeat (10) @(posedge core_clk);
      chk_bit(core_out.req, 1'b0);
      irq_line[14] <= 1'b0;
      // order, equal-priority pend, ties and fixed priorities
      lag <= 2'h3;
      setp(18, 5);
      setp(20, 3);
      setp(21, 3);
      setp(25, 3);
      irq_line[2] <= 1'b1;
      irq_line[5] <= 1'b1;
      wait_req();
      q = {18, 21};
      chk_num(winner(q));
      wait_take();
      irq_line[4] <= 1'b1;
      irq_line[9] <= 1'b1;
      repeat (8) @(posedge core_clk);
      chk_bit(core_out.req, 1'b0);
      bus(1'b0, W_STAT, 32'h0);
      chk_bit(rd[ST_EQPEND], 1'b1);
      irq_line[5] <= 1'b0;
      repeat (6) @(posedge core_clk);
      leave(21);
      wait_req();
      q = {18, 20, 25};
      chk_num(winner(q));
      wait_take();
      s = '0;
      s.nmi = 1'b1;
      s.hard_fault = 1'b1;
      sys(s);
      wait_req();
      q = {2, 3, 18, 25};
      chk_num(winner(q));
      chk_bit(core_out.preempt, 1'b1);
      wait_take();
      repeat (8) @(posedge core_clk);
      chk_bit(core_out.req, 1'b0);
      leave(2);
      wait_req();
      chk_num(EXC_HARD);
      chk_bit(core_out.preempt, 1'b1);
      wait_take();
      irq_line <= '0;
      repeat (6) @(posedge core_clk);
      leave(3);
      leave(20);
      // second reset drops the relocation
      rst_b <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      bus(1'b0, W_VTOR, 32'h0);
      chk_word(rd, 32'h0);
      chk_word(core_out.sp_addr, 32'h0);
      wrap_up();
   end
endmodule

bind evpa_arbiter evpa_monitor u_mon (.core_clk, .rst_b, .hsel, .htrans, .hwrite, .hready,
   .hrdata, .sys_req, .core_out);

`default_nettype wire
